// ---- rtl/gef_pkg.sv ----
// shared constants and carrier types for the graphics event flag block
package gef_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] GEF_OFS_FLAG   = 12'h000;
    localparam logic [11:0] GEF_OFS_MASK   = 12'h004;
    localparam logic [11:0] GEF_OFS_WMARK  = 12'h008;
    localparam logic [11:0] GEF_OFS_STATUS = 12'h00c;
    localparam int          GEF_ADDR_W     = 12;
    localparam int          GEF_DATA_W     = 32;

    // flag bit positions, shared by flag and mask registers
    localparam int GEF_NFLAG        = 8;
    localparam int GEF_BIT_EMPTY    = 0;
    localparam int GEF_BIT_FULL     = 1;
    localparam int GEF_BIT_WMARK    = 2;
    localparam int GEF_BIT_HBLANK   = 3;
    localparam int GEF_BIT_VBLANK   = 4;
    localparam int GEF_BIT_CHAR     = 5;
    localparam int GEF_BIT_RECT     = 6;
    localparam int GEF_BIT_INFLATE  = 7;

    // status register layout: live levels low, queue level from this bit up
    localparam int GEF_STAT_LVL_LSB = 16;

    // reset values
    localparam logic [7:0]  GEF_RST_FLAGS = 8'h00;
    localparam logic [7:0]  GEF_RST_MASK  = 8'h00;
    localparam logic [7:0]  GEF_RST_PREV  = 8'hff;
    localparam logic [31:0] GEF_RST_DATA  = 32'h0000_0000;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } gef_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gef_apb_rsp_t;

    // event sources, all on the system clock
    typedef struct packed {
        logic inflate_done;
        logic rect_copy_done;
        logic char_render_done;
        logic vert_blank;
        logic horiz_blank;
        logic cmd_queue_full;
        logic cmd_queue_empty;
    } gef_evt_t;
endpackage

// ---- rtl/gef_rise.sv ----
// rising edge finder for a bank of event levels
`timescale 1ns/100ps
module gef_rise #(
    parameter int N = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic [N-1:0] i_lvl,
    output logic      [N-1:0] o_rise
);
    typedef struct packed {
        logic [N-1:0] prev;
    } gef_rise_st_t;

    gef_rise_st_t st;
    gef_rise_st_t next_st;

    // remember last level
    always_comb begin
        next_st      = st;
        next_st.prev = i_lvl;
    end

    // preset high so levels already true at reset do not fire
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st.prev <= N'(gef_pkg::GEF_RST_PREV);
        end else begin
            st <= next_st;
        end
    end

    assign o_rise = i_lvl & ~st.prev;
endmodule // gef_rise

// ---- rtl/gef_flag_bank.sv ----
// sticky flag bank: hardware sets, software writes zero to clear
`timescale 1ns/100ps
module gef_flag_bank #(
    parameter int N = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic [N-1:0] i_set,
    input  wire logic         i_wr,
    input  wire logic [N-1:0] i_wdata,
    output logic      [N-1:0] o_flags
);
    typedef struct packed {
        logic [N-1:0] flags;
    } gef_bank_st_t;

    gef_bank_st_t st;
    gef_bank_st_t next_st;
    logic [N-1:0] clr;

    // a zero written clears; set is or-ed last so it wins a tie
    always_comb begin
        next_st       = st;
        clr           = i_wr ? ~i_wdata : '0;                  // [R11]
        next_st.flags = (st.flags & ~clr) | i_set;             // [R11]
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st.flags <= N'(gef_pkg::GEF_RST_FLAGS);
        end else begin
            st <= next_st;
        end
    end

    assign o_flags = st.flags;
endmodule // gef_flag_bank

// ---- rtl/gef_top.sv ----
// graphics event flags: sticky flags, mask, irq and apb slave
//
// What this block does
// [R1] rect copy done sets bit 6, sticky
// [R2] char render done sets bit 5, sticky
// [R3] inflate flag zero while unit idle/busy
// [R4] vertical blanking entry sets bit 4, sticky
// [R5] horizontal blanking entry sets bit 3, sticky
// [R6] queue level reaching watermark sets bit 2
// [R7] queue becoming full sets bit 1, sticky
// [R8] queue drained sets bit 0 flag
// [R9] inflate unit done sets bit 7, sticky
// [R10] bits 14 to 8 read zero
// [R11] write zero clears; set beats clear
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module gef_top #(
    parameter int LVL_W = 8
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_arst_n,
    input  wire gef_pkg::gef_apb_req_t i_apb,
    output gef_pkg::gef_apb_rsp_t     o_apb,
    input  wire gef_pkg::gef_evt_t    i_evt,
    input  wire logic [LVL_W-1:0]     i_cmd_level,
    output logic                      o_irq
);
    localparam int NF = gef_pkg::GEF_NFLAG;

    // whole register state of the top
    typedef struct packed {
        logic [NF-1:0]    mask;
        logic [LVL_W-1:0] wmark;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
    } gef_top_st_t;

    gef_top_st_t   st;
    gef_top_st_t   next_st;

    logic [NF-1:0] cond;
    logic [NF-1:0] rise;
    logic [NF-1:0] flags;
    logic          wm_reached;
    logic          first_acc;
    logic          done_acc;
    logic          flag_wr;

    // word address match, upper address bits must match too
    function automatic logic gef_hit(input logic [11:0] addr,
                                     input logic [11:0] ofs);
        gef_hit = (addr[11:2] == ofs[11:2]);
    endfunction

    // watermark counts as reached at or above the programmed level
    assign wm_reached = (i_cmd_level >= st.wmark);             // [R6]

    // conditions gathered at their flag positions
    always_comb begin
        cond                           = '0;
        cond[gef_pkg::GEF_BIT_EMPTY]   = i_evt.cmd_queue_empty;  // [R8]
        cond[gef_pkg::GEF_BIT_FULL]    = i_evt.cmd_queue_full;   // [R7]
        cond[gef_pkg::GEF_BIT_WMARK]   = wm_reached;             // [R6]
        cond[gef_pkg::GEF_BIT_HBLANK]  = i_evt.horiz_blank;      // [R5]
        cond[gef_pkg::GEF_BIT_VBLANK]  = i_evt.vert_blank;       // [R4]
        cond[gef_pkg::GEF_BIT_CHAR]    = i_evt.char_render_done; // [R2]
        cond[gef_pkg::GEF_BIT_RECT]    = i_evt.rect_copy_done;   // [R1]
        cond[gef_pkg::GEF_BIT_INFLATE] = i_evt.inflate_done;     // [R9]
    end

    // edges, so a flag cleared during a long blank stays clear
    gef_rise #(
        .N (NF)
    ) u_rise (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_lvl    (cond),
        .o_rise   (rise)
    );

    // sticky flags; no set while a unit stays idle or busy
    gef_flag_bank #(
        .N (NF)
    ) u_flags (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_set    (rise),                                      // [R1] [R2] [R3] [R9]
        .i_wr     (flag_wr),
        .i_wdata  (i_apb.pwdata[NF-1:0]),
        .o_flags  (flags)
    );

    // apb phases: first access edge latches read data, second completes
    assign first_acc = i_apb.psel & i_apb.penable & ~st.pready;
    assign done_acc  = i_apb.psel & i_apb.penable & st.pready;

    // writes land only on the edge where pready is sampled high
    assign flag_wr = done_acc & i_apb.pwrite
                   & gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_FLAG); // [R11]

    // done pulses are not levels worth showing in status
    function automatic logic [NF-1:0] rise_mask_done();
        rise_mask_done = '0;
        rise_mask_done[gef_pkg::GEF_BIT_CHAR]    = 1'b1;
        rise_mask_done[gef_pkg::GEF_BIT_RECT]    = 1'b1;
        rise_mask_done[gef_pkg::GEF_BIT_INFLATE] = 1'b1;
    endfunction

    // register next state
    always_comb begin
        next_st         = st;
        next_st.pready  = first_acc;
        next_st.pslverr = 1'b0;
        next_st.prdata  = gef_pkg::GEF_RST_DATA;
        if (first_acc) begin
            if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_FLAG)) begin
                // upper bits, 14 to 8 among them, read zero
                next_st.prdata = 32'(flags);                   // [R10]
            end else if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_MASK)) begin
                next_st.prdata = 32'(st.mask);
            end else if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_WMARK)) begin
                next_st.prdata = 32'(st.wmark);
            end else if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_STATUS)) begin
                // live levels plus queue level, read only
                next_st.prdata = 32'(cond & ~rise_mask_done())
                               | (32'(i_cmd_level) << gef_pkg::GEF_STAT_LVL_LSB);
            end else begin
                next_st.pslverr = 1'b1;                        // unmapped
            end
            if (i_apb.pwrite) begin
                next_st.prdata = gef_pkg::GEF_RST_DATA;
            end
        end
        if (done_acc && i_apb.pwrite) begin
            if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_MASK)) begin
                next_st.mask = i_apb.pwdata[NF-1:0];
            end else if (gef_hit(i_apb.paddr, gef_pkg::GEF_OFS_WMARK)) begin
                next_st.wmark = i_apb.pwdata[LVL_W-1:0];
            end
        end
        // level irq, one cycle behind the flag it follows
        next_st.irq = |(flags & st.mask);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st.mask    <= gef_pkg::GEF_RST_MASK;
            st.wmark   <= '0;
            st.prdata  <= gef_pkg::GEF_RST_DATA;
            st.pready  <= 1'b0;
            st.pslverr <= 1'b0;
            st.irq     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // all outputs straight from flops
    assign o_apb.prdata  = st.prdata;
    assign o_apb.pready  = st.pready;
    assign o_apb.pslverr = st.pslverr;
    assign o_irq         = st.irq;
endmodule // gef_top

// ---- sim/gef_checker.sv ----
// concurrent checks on the graphics event flag block ports
`timescale 1ns/100ps
module gef_checker (
    input wire logic                  i_clk,
    input wire logic                  i_arst_n,
    input wire gef_pkg::gef_apb_req_t i_apb,
    input wire gef_pkg::gef_apb_rsp_t o_apb,
    input wire gef_pkg::gef_evt_t     i_evt,
    input wire logic                  o_irq
);
    logic [7:0] m;
    logic [7:0] fe;
    logic       done;
    // events laid out like the flag bits, watermark slot left empty
    assign fe   = {i_evt[6:2], 1'b0, i_evt[1:0]};
    assign done = i_apb.psel && i_apb.penable && o_apb.pready;
    // mask shadow, follows completed writes only
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            m <= 8'h00;
        else if (done && i_apb.pwrite && i_apb.paddr[11:2] == 10'h001)
            m <= i_apb.pwdata[7:0];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    wait_state_a: assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
        else $error("pready late");
    pulse_once_a: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("pready held");
    err_decode_a: assert property (done |-> o_apb.pslverr == (i_apb.paddr[11:4] != 8'h00))
        else $error("slave error decode wrong");
    idle_data_a: assert property (!o_apb.pready |-> o_apb.prdata == 32'h0)
        else $error("read data outside answer");
    rsv_zero_a: assert property (done && !i_apb.pwrite && i_apb.paddr[11:2] == 10'h000
        |-> o_apb.prdata[31:8] == 24'h0) else $error("unused flag bits set");
    irq_off_a: assert property (m == 8'h00 |=> !o_irq)
        else $error("irq while all masked");
    // a write of zeros with no new event must drop the irq two edges on
    flag_clear_a: assert property (done && i_apb.pwrite && i_apb.paddr[11:2] == 10'h000 && !(|(fe & ~$past(fe)))
        && i_apb.pwdata[7:0] == 8'h00 |-> ##2 !o_irq) else $error("clear left irq high");
    for (genvar i = 0; i < 8; i++) begin : g_set
        if (i != 2) begin : g_b
            set_irq_a: assert property ($rose(fe[i]) && m[i] |-> ##2 o_irq)
                else $error("event did not raise irq");
        end
    end
endmodule // gef_checker

bind gef_top gef_checker chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(i_apb), .o_apb(o_apb),
                                .i_evt(i_evt), .o_irq(o_irq));

// ---- sim/gef_top_tb.sv ----
// self-checking bench for the graphics event flag block
`timescale 1ns/100ps
module gef_top_tb;
    logic                  i_clk;
    logic                  rst_n;
    gef_pkg::gef_apb_req_t req;
    gef_pkg::gef_apb_rsp_t rsp;
    logic [6:0]            ev;
    logic [7:0]            lvl;
    logic                  irq;
    logic [33:0]           notes[$];
    logic [33:0]           note;
    logic [15:0]           r;
    int                    fb;
    int                    errors;
    int                    compares;

    gef_top dut_u (.i_clk(i_clk), .i_arst_n(rst_n), .i_apb(req), .o_apb(rsp),
                   .i_evt(gef_pkg::gef_evt_t'(ev)), .i_cmd_level(lvl), .o_irq(irq));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_irq(input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: irq expected %h got %h", $time, e, g);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer; a read leaves its expected {irq, pslverr, prdata}
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        @(posedge i_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        if (!wr)
            notes.push_back(e);
        @(posedge i_clk);
        req.penable <= 1'b1;
        @(posedge i_clk);
        while (rsp.pready !== 1'b1)
            @(posedge i_clk);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // 100 mhz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // completed reads are matched against the oldest note
    always @(posedge i_clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && notes.size() > 0) begin
            note = notes.pop_front();
            cmp(note[32:0], {rsp.pslverr, rsp.prdata});
            cmp_irq(note[33], irq);
        end
    end

    // a hang ends the run well past the few hundred cycles needed
    initial begin
        #100000;
        errors++;
        print_verdict();
    end

    initial begin
        req      = '0;
        ev       = 7'h00;
        lvl      = 8'h00;
        rst_n    = 1'b0;
        errors   = 0;
        compares = 0;
        r        = 16'h9325;
        repeat (4) @(posedge i_clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 34'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        repeat (2) begin
            r = lfsr(r);
            apb(1'b1, 12'h004, {r, r}, 33'h0);
            apb(1'b0, 12'h004, 32'h0, {25'h0, r[7:0]});
        end
        apb(1'b1, 12'h004, 32'hff, 33'h0);
        // pulse each event alone, then try a ones write and a zeros write
        for (int b = 0; b < 7; b++) begin
            fb = (b < 2) ? b : b + 1;
            @(posedge i_clk);
            ev <= 7'h01 << b;
            @(posedge i_clk);
            ev <= 7'h00;
            apb(1'b0, 12'h000, 32'h0, {1'b1, 33'h1 << fb});
            apb(1'b1, 12'h000, 32'hffff_ffff, 34'h0);
            apb(1'b0, 12'h000, 32'h0, {1'b1, 33'h1 << fb});
            apb(1'b1, 12'h000, 32'h0, 34'h0);
            apb(1'b0, 12'h000, 32'h0, 34'h0);
        end
        // watermark: one below stays quiet, reaching it sets bit 2
        apb(1'b1, 12'h008, 32'h5, 33'h0);
        apb(1'b1, 12'h000, 32'h0, 33'h0);
        lvl <= 8'h04;
        apb(1'b0, 12'h000, 32'h0, 34'h0);
        lvl <= 8'h05;
        apb(1'b0, 12'h000, 32'h0, {1'b1, 33'h4});
        apb(1'b0, 12'h008, 32'h0, {1'b1, 33'h5});
        // status shows live watermark level and queue fill
        apb(1'b0, 12'h00c, 32'h0, {1'b1, 33'h5_0004});
        // a clear during a held level must stay clear
        apb(1'b1, 12'h000, 32'h0, 34'h0);
        apb(1'b0, 12'h000, 32'h0, 34'h0);
        // let the monitor take the last answer first
        repeat (2) @(posedge i_clk);
        print_verdict();
    end
endmodule // gef_top_tb
